// *** data_flash_byte_access.sv ***
// data flash byte access controller with axi4-lite register slave
// assumes cpu stall is honoured by the core; array storage is flip-flops
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module data_flash_byte_access (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write channels
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [15:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // axi4-lite read channels
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [15:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // configuration and system
    input  wire logic        data_protect_n,
    output logic             cpu_stall,
    output logic             flash_done_irq
);
    import flash_pkg::*;

    // ************************************************************************
    // register state
    // ************************************************************************
    logic [14:0] flash_address, next_flash_address;
    logic [13:0] flash_data, next_flash_data;
    logic        region_select, next_region_select;
    logic        program_permit, next_program_permit;
    logic        program_fault_flag, next_program_fault_flag;
    logic        wr_busy, next_wr_busy;
    logic        rd_trig, next_rd_trig;
    logic        flash_done_flag, next_flash_done_flag;
    logic        flash_done_irq_enable, next_flash_done_irq_enable;
    logic [15:0] indirect_pointer, next_indirect_pointer;
    logic [7:0]  indirect_data, next_indirect_data;
    logic [7:0]  data_flash_array [DFM_BYTES];
    logic [8:0]  timer, next_timer;
    prog_state_t pstate, next_pstate;
    key_state_t  kstate, next_kstate;
    logic        aw_held, next_aw_held, w_held, next_w_held;
    logic [15:0] aw_addr_q, next_aw_addr_q;
    logic [31:0] w_data_q, next_w_data_q;
    logic        next_bvalid, next_rvalid, next_cpu_stall, next_irq;
    logic [31:0] next_rdata;
    logic [1:0]  next_bresp, next_rresp;
    logic        do_write, array_we;
    logic [15:0] widx;
    logic [7:0]  wbyte;

    // register index from a byte address; unaligned bits ignored
    function automatic logic [15:0] reg_index(input logic [15:0] a);
        return a >> ADDR_SHIFT;
    endfunction

    // decode of a data flash location, used by the read-trigger path only; indirect reads decode DFM_NIBBLE
    function automatic logic dfm_hit(input logic [15:0] a);
        return a[15:7] == DFM_BASE[15:7];
    endfunction

    // did a protected-address write trigger happen; protect covers whole array
    function automatic logic blocked();
        return !data_protect_n || !region_select;
    endfunction

    // ************************************************************************
    // axi write path and register writes
    // ************************************************************************
    assign do_write = aw_held && w_held && !bvalid;
    assign widx     = reg_index(aw_addr_q);
    assign wbyte    = w_data_q[7:0];

    always_comb begin
        next_aw_held            = aw_held;
        next_w_held             = w_held;
        next_aw_addr_q          = aw_addr_q;
        next_w_data_q           = w_data_q;
        next_bvalid             = bvalid;
        next_bresp              = bresp;
        next_flash_address      = flash_address;
        next_flash_data         = flash_data;
        next_region_select      = region_select;
        next_program_permit     = program_permit;
        next_program_fault_flag = program_fault_flag;
        next_rd_trig            = 1'b0; // [R10]
        next_flash_done_flag    = flash_done_flag;
        next_flash_done_irq_enable = flash_done_irq_enable;
        next_indirect_pointer   = indirect_pointer;
        next_kstate             = kstate;
        next_wr_busy            = wr_busy;
        next_pstate             = pstate;
        next_timer              = timer;
        array_we                = 1'b0;
        if (awvalid && awready) begin
            next_aw_held   = 1'b1;
            next_aw_addr_q = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held   = 1'b1;
            next_w_data_q = wstrb[0] ? wdata : 32'h0000_0000;
        end
        if (bvalid && bready)
            next_bvalid = 1'b0;
        // writes during a busy program are held off until wr_busy clears
        if (do_write && !wr_busy) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            case (widx)
                ADDR_OFFSET: next_flash_address = w_data_q[14:0]; // [R20]
                DATA_OFFSET: next_flash_data = w_data_q[13:0]; // [R9] [R22]
                KEY_OFFSET: begin
                    // key register only steps or resets the tracker and can set the fault flag, never reads back
                    if (kstate == KEY_IDLE && wbyte == KEY_FIRST)
                        next_kstate = KEY_GOT55; // [R11] [R24]
                    else if (kstate == KEY_GOT55 && wbyte == KEY_SECOND)
                        next_kstate = KEY_ARMED;
                    else begin
                        next_kstate = KEY_IDLE; // [R25]
                        if (kstate != KEY_IDLE)
                            next_program_fault_flag = 1'b1; // [R18]
                    end
                end
                CTRL_OFFSET: begin
                    next_region_select  = wbyte[BIT_REGS]; // [R23]
                    next_program_permit = wbyte[BIT_PROGRAM_PERMIT];
                    next_program_fault_flag = wbyte[BIT_FAULT]; // [R19]
                    if (wbyte[BIT_RD])
                        next_rd_trig = 1'b1; // [R8]
                    if (wbyte[BIT_WR] && kstate == KEY_ARMED && wbyte[BIT_PROGRAM_PERMIT]) begin
                        if (blocked())
                            next_program_fault_flag = 1'b1; // [R7] [R16] [R18]
                        else begin
                            next_wr_busy = 1'b1; // [R11] [R26]
                            next_pstate  = ST_ERASE; // [R2]
                            next_timer   = ERASE_CYCLES; // [R3]
                        end
                    end
                end
                IRQ_OFFSET: begin
                    next_flash_done_irq_enable = wbyte[1];
                    next_flash_done_flag = wbyte[0];
                end
                PTR_OFFSET: next_indirect_pointer = w_data_q[15:0];
                default: next_bresp = RESP_SLVERR; // [R6] indirect data ignored
            endcase
            // any write but the next key step disarms the tracker; placed after
            // the decode so a broken unlock beats a software clear of the flag
            if (widx != KEY_OFFSET && kstate != KEY_IDLE) begin
                next_kstate = KEY_IDLE; // [R25]
                if (!(widx == CTRL_OFFSET && wbyte[BIT_WR] && kstate == KEY_ARMED))
                    next_program_fault_flag = 1'b1; // [R18]
            end
        end
        // read trigger: byte appears in the low data register next cycle
        if (rd_trig) begin
            if (region_select && dfm_hit({1'b1, flash_address}))
                next_flash_data = {6'h00, data_flash_array[flash_address[6:0]]}; // [R1] [R8]
            else
                next_flash_data = 14'h0000;
        end
        // self-timed erase then program sequence
        case (pstate)
            ST_IDLE: ;
            ST_ERASE, ST_PROG: begin
                next_timer = timer - 9'd1;
                if (timer == 9'd1) begin
                    if (pstate == ST_ERASE) begin
                        next_pstate = ST_PROG; // [R2]
                        next_timer  = WRITE_CYCLES; // [R3]
                    end else begin
                        next_pstate = ST_DONE;
                        array_we    = 1'b1; // [R14] [R15]
                    end
                end
            end
            ST_DONE: begin
                next_wr_busy         = 1'b0; // [R17]
                next_flash_done_flag = 1'b1; // set wins over clear [R17]
                next_pstate          = ST_IDLE;
            end
            default: next_pstate = ST_IDLE;
        endcase
    end

    // ************************************************************************
    // indirect read path and axi read channel
    // ************************************************************************
    always_comb begin
        next_indirect_data = indirect_data;
        next_rvalid        = rvalid;
        next_rdata         = rdata;
        next_rresp         = rresp;
        // pointer with 0111 high nibble reaches the array [R4]
        if (indirect_pointer[15:12] == DFM_NIBBLE)
            next_indirect_data = (indirect_pointer[11:7] == 5'h00)
                ? data_flash_array[indirect_pointer[6:0]] : 8'h00; // [R5]
        else
            next_indirect_data = 8'h00; // [R5]
        if (rvalid && rready)
            next_rvalid = 1'b0;
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (reg_index(araddr))
                // bit 15 reads zero while writing [R21]
                ADDR_OFFSET: next_rdata = {17'h0, flash_address};
                DATA_OFFSET: next_rdata = {18'h0, flash_data};
                CTRL_OFFSET: next_rdata = {25'h0, region_select, 2'b00,
                    program_fault_flag, program_permit, wr_busy, rd_trig};
                KEY_OFFSET:  next_rdata = 32'h0000_0000; // [R24]
                IRQ_OFFSET:  next_rdata = {30'h0, flash_done_irq_enable, flash_done_flag};
                PTR_OFFSET:  next_rdata = {16'h0, indirect_pointer};
                IND_OFFSET:  next_rdata = {24'h0, indirect_data};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        next_cpu_stall = next_wr_busy || next_rd_trig; // [R12]
        next_irq       = next_flash_done_flag && next_flash_done_irq_enable; // [R17]
    end

    // ready only when the channel has room; one write and one read at a time
    always_comb begin
        awready = !aw_held && !bvalid && aresetn;
        wready  = !w_held && !bvalid && aresetn;
        arready = !rvalid && aresetn;
    end

    // ************************************************************************
    // registers
    // ************************************************************************
    always_ff @(posedge aclk) begin
        flash_data    <= next_flash_data; // not reset [R22]
        indirect_data <= next_indirect_data;
        aw_addr_q     <= next_aw_addr_q;
        w_data_q      <= next_w_data_q;
        if (array_we)
            data_flash_array[flash_address[6:0]] <= flash_data[7:0]; // [R1]
        if (!aresetn) begin
            flash_address         <= 15'h0000;
            region_select         <= 1'b0;
            program_permit        <= 1'b0;
            // reset during a self-write leaves a mark [R18]
            program_fault_flag    <= program_fault_flag | wr_busy;
            wr_busy               <= 1'b0;
            rd_trig               <= 1'b0;
            flash_done_flag       <= 1'b0;
            flash_done_irq_enable <= 1'b0;
            indirect_pointer      <= 16'h0000;
            timer                 <= 9'h000;
            pstate                <= ST_IDLE;
            kstate                <= KEY_IDLE;
            aw_held               <= 1'b0;
            w_held                <= 1'b0;
            bvalid                <= 1'b0;
            bresp                 <= RESP_OKAY;
            rvalid                <= 1'b0;
            rdata                 <= 32'h0000_0000;
            rresp                 <= RESP_OKAY;
            cpu_stall             <= 1'b0;
            flash_done_irq        <= 1'b0;
        end else begin
            flash_address         <= next_flash_address;
            region_select         <= next_region_select;
            program_permit        <= next_program_permit;
            program_fault_flag    <= next_program_fault_flag;
            wr_busy               <= next_wr_busy;
            rd_trig               <= next_rd_trig;
            flash_done_flag       <= next_flash_done_flag;
            flash_done_irq_enable <= next_flash_done_irq_enable;
            indirect_pointer      <= next_indirect_pointer;
            timer                 <= next_timer;
            pstate                <= next_pstate;
            kstate                <= next_kstate;
            aw_held               <= next_aw_held;
            w_held                <= next_w_held;
            bvalid                <= next_bvalid;
            bresp                 <= next_bresp;
            rvalid                <= next_rvalid;
            rdata                 <= next_rdata;
            rresp                 <= next_rresp;
            cpu_stall             <= next_cpu_stall;
            flash_done_irq        <= next_irq;
        end
    end

    // ************************************************************************
    // assertions
    // ************************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_read_clears;
        rd_trig |=> !rd_trig;
    endproperty
    a_read_clears: assert property (p_read_clears) // [R10]
        else $error("read trigger not cleared");

    property p_protect;
        !data_protect_n |-> ##1 !$rose(wr_busy);
    endproperty
    a_protect: assert property (p_protect) // [R7]
        else $error("write started while protected");

    property p_permit;
        $rose(wr_busy) |-> $past(next_program_permit);
    endproperty
    a_permit: assert property (p_permit) // [R26]
        else $error("write started without permit");

    property p_armed;
        $rose(wr_busy) |-> $past(kstate) == KEY_ARMED;
    endproperty
    a_armed: assert property (p_armed) // [R11]
        else $error("write started without unlock");

    property p_timed;
        $rose(wr_busy) |-> wr_busy [*8];
    endproperty
    a_timed: assert property (p_timed) // [R3]
        else $error("program ended too early");

    property p_done;
        $fell(wr_busy) |-> flash_done_flag;
    endproperty
    a_done: assert property (p_done) // [R17]
        else $error("done flag missing");

    property p_stall;
        wr_busy |-> cpu_stall;
    endproperty
    a_stall: assert property (p_stall) // [R12]
        else $error("cpu not stalled");

    property p_erase_first;
        $rose(wr_busy) |-> pstate == ST_ERASE;
    endproperty
    a_erase_first: assert property (p_erase_first) // [R2]
        else $error("program without erase");

    c_write: cover property ($fell(wr_busy));
    c_read: cover property (rd_trig);
    c_fault: cover property ($rose(program_fault_flag));
endmodule

// *** flash_pkg.sv ***
// package for the data flash byte access controller
// assumes an axi4-lite master on aclk; array storage is flip-flops inside the controller
// ****************************************************************************
// Overview of operation
// (R1) flash read and written one byte at a time, data in the low data byte
// (R2) every byte write first erases the location, then programs the new value
// (R3) erase/program length set by an internal programming timer
// (R4) pointer high nibble 0111 selects data flash for indirect reads
// (R5) indirect read of an unimplemented location returns zero
// (R6) indirect writes aimed at the data flash are ignored
// (R7) erase or write blocked while the protect bit reads zero
// (R8) read: region select, address, read trigger; byte ready the next cycle
// (R9) low data byte keeps read result until next read or software write
// (R10) hardware clears the read trigger when the read completes
// (R11) write starts only after 55h, then aah, then write trigger, in order
// (R12) cpu stalled from write trigger until the operation finishes
// (R13) software disables global interrupts around the unlock sequence
// (R14) erase is a write of ffh with the usual unlock steps
// (R15) program: region, address, data, permit, irq off, unlock, trigger
// (R16) protected address: write trigger cleared, nothing written
// (R17) completion clears write trigger, sets done flag, irq if enabled
// (R18) fault flag set on protected trigger, reset mid write, broken unlock
// (R19) fault flag cleared only by software, software may set it
// (R20) address register holds 15 bits in bits 14 to 0
// (R21) address bit 15 undefined (reads zero here) while writing
// (R22) data register holds 14 bits, untouched by reset
// (R23) region select 1 steers register access to data flash
// (R24) unlock key register write only, resets to zero
// (R25) unlock tracker returns idle on any unexpected write
// (R26) write trigger without program permit starts nothing
// ****************************************************************************
package flash_pkg;
    localparam logic [15:0] ADDR_OFFSET   = 16'h1c8c;
    localparam logic [15:0] DATA_OFFSET   = 16'h1c8e;
    localparam logic [15:0] CTRL_OFFSET   = 16'h1c90;
    localparam logic [15:0] KEY_OFFSET    = 16'h1c91;
    localparam logic [15:0] IRQ_OFFSET    = 16'h1c92;
    localparam logic [15:0] PTR_OFFSET    = 16'h1c93;
    localparam logic [15:0] IND_OFFSET    = 16'h1c94;
    // byte address is index times four
    localparam int          ADDR_SHIFT    = 2;
    localparam int          BIT_RD        = 0;
    localparam int          BIT_WR        = 1;
    localparam int          BIT_PROGRAM_PERMIT      = 2;
    localparam int          BIT_FAULT     = 3;
    localparam int          BIT_REGS      = 6;
    localparam logic [7:0]  KEY_FIRST     = 8'h55;
    localparam logic [7:0]  KEY_SECOND    = 8'haa;
    localparam logic [3:0]  DFM_NIBBLE    = 4'h7;
    localparam logic [15:0] DFM_BASE      = 16'hf000;
    localparam int          DFM_BYTES     = 128;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;
    localparam int          PROG_TIME_US  = 4;
    localparam int          CLK_MHZ       = 100;
    localparam int          PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam logic [8:0]  ERASE_CYCLES  = 9'(PROG_CYCLES / 2);
    localparam logic [8:0]  WRITE_CYCLES  = 9'(PROG_CYCLES);
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ERASE = 4'b0010,
        ST_PROG  = 4'b0100,
        ST_DONE  = 4'b1000
    } prog_state_t;
    typedef enum logic [2:0] {
        KEY_IDLE  = 3'b001,
        KEY_GOT55 = 3'b010,
        KEY_ARMED = 3'b100
    } key_state_t;
endpackage

// *** axi_cpu_model.sv ***
// cpu software model: an axi4-lite master that drives the flash controller registers
// assumes one aclk; tasks are called by the bench only after reset is released
`timescale 1ns/100ps
module axi_cpu_model
    import flash_pkg::*;
(
    // clock and status
    input  wire logic        aclk,
    input  wire logic        cpu_stall,
    // write channels
    output logic             awvalid,
    input  wire logic        awready,
    output logic [15:0]      awaddr,
    output logic             wvalid,
    input  wire logic        wready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    input  wire logic        bvalid,
    output logic             bready,
    input  wire logic [1:0]  bresp,
    // read channels
    output logic             arvalid,
    input  wire logic        arready,
    output logic [15:0]      araddr,
    input  wire logic        rvalid,
    output logic             rready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp
);
    // ****************************************************************
    // bus tasks
    // ****************************************************************
    logic stall_seen = 1'b0;
    logic global_irq_enable = 1'b1;

    // idle bus from time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, wstrb, araddr} = '0;
    end

    // address and data offered together, each released once taken
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge aclk);
        awaddr  <= idx << ADDR_SHIFT;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!tb) begin
            // sampled mid-cycle, so the value holds at the next rising edge
            @(negedge aclk);
            ta = awready;
            tw = wready;
            tb = bvalid;
            r  = bresp;
            stall_seen = stall_seen | cpu_stall;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask

    // read address held until taken, rready until data comes
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        tr = 1'b0;
        while (cpu_stall) @(negedge aclk); // stalled cpu issues no read
        @(posedge aclk);
        araddr  <= idx << ADDR_SHIFT;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = arready;
            tr = rvalid;
            d  = rdata;
            r  = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
    endtask

    // key steps then trigger, nothing in between, interrupts held off
    task automatic unlock_go(input logic [31:0] ctrl);
        logic [1:0] r;
        global_irq_enable = 1'b0;
        wr(KEY_OFFSET, 32'(KEY_FIRST), r);
        wr(KEY_OFFSET, 32'(KEY_SECOND), r);
        wr(CTRL_OFFSET, ctrl, r);
        global_irq_enable = 1'b1;
    endtask
endmodule

// *** tb_data_flash_byte_access.sv ***
// self-checking bench for the data flash byte access controller
// assumes the cpu model drives the register bus; short programming times in use
`timescale 1ns/100ps
module tb_data_flash_byte_access;
    import flash_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn, data_protect_n, cpu_stall, flash_done_irq;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          error_cnt = 0;
    int          comparisons = 0;

    data_flash_byte_access uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .data_protect_n(data_protect_n),
        .cpu_stall(cpu_stall), .flash_done_irq(flash_done_irq));
    axi_cpu_model m (.aclk(aclk), .cpu_stall(cpu_stall), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp));

    // ****************************************************************
    // checking tasks
    // ****************************************************************
    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // register read compared under a mask, the high data byte being unspecified
    task automatic rchk(input string name, input logic [15:0] idx, input logic [31:0] exp,
                        input logic [31:0] mk = 32'hffffffff);
        m.rd(idx, d, r);
        chk(name, d & mk, exp);
    endtask

    task automatic prog(input logic [15:0] a, input logic [7:0] v, input logic [31:0] go);
        m.wr(ADDR_OFFSET, 32'(a), r);
        m.wr(DATA_OFFSET, 32'(v), r);
        m.wr(CTRL_OFFSET, go & ~32'h2, r);
        m.unlock_go(go);
    endtask

    task automatic fread(input logic [15:0] a, input logic [31:0] exp, input string name);
        m.wr(ADDR_OFFSET, 32'(a), r);
        m.wr(CTRL_OFFSET, 32'h41, r);
        rchk(name, DATA_OFFSET, exp, 32'hff);
    endtask

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        aresetn = 1'b0;
        data_protect_n = 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("addr reset", ADDR_OFFSET, 32'h0);
        rchk("ctrl reset", CTRL_OFFSET, 32'h0);
        m.wr(ADDR_OFFSET, 32'hf005, r);
        rchk("addr width", ADDR_OFFSET, 32'h7005);
        m.wr(DATA_OFFSET, 32'hffff, r);
        rchk("data width", DATA_OFFSET, 32'h3fff);
        m.stall_seen = 1'b0;
        prog(16'h7005, 8'h5a, 32'h46);
        chk("stall", 32'(m.stall_seen), 32'h1);
        rchk("ctrl done", CTRL_OFFSET, 32'h44);
        rchk("done flag", IRQ_OFFSET, 32'h1);
        fread(16'h7005, 32'h5a, "byte");
        rchk("rd clear", CTRL_OFFSET, 32'h40);
        m.wr(ADDR_OFFSET, 32'h7006, r);
        rchk("data held", DATA_OFFSET, 32'h5a, 32'hff);
        // indirect path is read only and limited to the implemented bytes
        m.wr(PTR_OFFSET, 32'h7005, r);
        rchk("ind read", IND_OFFSET, 32'h5a, 32'hff);
        m.wr(IND_OFFSET, 32'h11, r);
        rchk("ind write", IND_OFFSET, 32'h5a, 32'hff);
        m.wr(PTR_OFFSET, 32'h7080, r);
        rchk("ind unimpl", IND_OFFSET, 32'h0);
        // protected write, then fault flag held, cleared and set by software
        @(posedge aclk);
        data_protect_n <= 1'b0;
        prog(16'h7005, 8'h33, 32'h46);
        rchk("prot fault", CTRL_OFFSET, 32'h4c);
        m.wr(ADDR_OFFSET, 32'h7005, r);
        rchk("fault kept", CTRL_OFFSET, 32'h4c);
        m.wr(CTRL_OFFSET, 32'h40, r);
        rchk("fault clear", CTRL_OFFSET, 32'h40);
        m.wr(CTRL_OFFSET, 32'h48, r);
        rchk("fault set", CTRL_OFFSET, 32'h48);
        data_protect_n <= 1'b1;
        fread(16'h7005, 32'h5a, "prot keep");
        // unlock broken by a foreign write, then a stale trigger
        m.wr(CTRL_OFFSET, 32'h44, r);
        m.wr(KEY_OFFSET, 32'h55, r);
        m.wr(DATA_OFFSET, 32'h33, r);
        rchk("broken key", CTRL_OFFSET, 32'h4c);
        m.wr(KEY_OFFSET, 32'haa, r);
        m.wr(CTRL_OFFSET, 32'h46, r);
        fread(16'h7005, 32'h5a, "stale trig");
        prog(16'h7005, 8'h77, 32'h42);
        fread(16'h7005, 32'h5a, "no permit");
        // erase with the completion interrupt enabled
        m.wr(IRQ_OFFSET, 32'h2, r);
        chk("irq off", 32'(flash_done_irq), 32'h0);
        prog(16'h7005, ERASED_BYTE, 32'h46);
        fread(16'h7005, 32'hff, "erase");
        @(negedge aclk);
        chk("irq on", 32'(flash_done_irq), 32'h1);
        m.rd(16'h1c95, d, r);
        chk("unmapped rd", 32'(r), 32'(RESP_SLVERR));
        m.wr(16'h1c95, 32'h1, r);
        chk("unmapped wr", 32'(r), 32'(RESP_SLVERR));
        end_of_test();
    end

    // watchdog sized well above the expected run of some fifteen hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        end_of_test();
    end
endmodule
